// file: inc/hbfm_pkg.sv
// Constants shared by the half-bridge fault manager files
package hbfm_pkg;
  localparam int HBFM_CHANNELS = 6;
  localparam int HBFM_FRAME_BITS = 16;
  localparam logic [4:0] HBFM_FRAME_LEN = 5'h10;
  // Frame field positions
  localparam int HBFM_POS_STATUS_RESET = 15;
  localparam int HBFM_POS_ULD_SHUTDOWN = 13;
  localparam int HBFM_POS_ENABLE_LSB = 7;
  localparam int HBFM_POS_CONFIG_LSB = 1;
  localparam int HBFM_POS_OV_LOCKOUT = 0;
  // Reset values
  localparam logic [5:0] HBFM_RST_CHANNEL = 6'h00;
  localparam logic HBFM_RST_OV_LOCKOUT = 1'h0;
  localparam logic HBFM_RST_ULD_SHUTDOWN = 1'h0;
  localparam logic [15:0] HBFM_RST_WORD = 16'h0000;
endpackage

// file: inc/hbfm_sync_if.sv
// Raw and cleaned levels carried between the top and a synchroniser
`timescale 1ns/10ps
interface hbfm_sync_if #(
  parameter int WIDTH = 1
);
  logic [WIDTH-1:0] raw;
  logic [WIDTH-1:0] clean;
  modport sync (input raw, output clean);
  modport user (output raw, input clean);
endinterface

// file: rtl/hbfm_sync.sv
// Three-stage synchroniser that passes a bit once stages two and three agree
`timescale 1ns/10ps
module hbfm_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  hbfm_sync_if.sync port
);
  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;
  logic [WIDTH-1:0] clean_q;
  logic [WIDTH-1:0] clean_d;

  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      clean_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : clean_q[i];
    end
  end

  always_ff @(posedge clk) begin
    s1_q <= port.raw;
    s2_q <= s1_q;
    s3_q <= s2_q;
    clean_q <= clean_d;
  end

  assign port.clean = clean_q;
endmodule

// file: rtl/hbfm_top.sv
// Fault manager for a six-channel half-bridge driver behind a 16-bit serial port
`timescale 1ns/10ps
module hbfm_top
  import hbfm_pkg::*;
#(
  parameter int CHANNELS = HBFM_CHANNELS
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic link_clk,
  input wire logic link_frame_end,
  input wire logic [4:0] link_frame_count,
  input wire logic [HBFM_FRAME_BITS-1:0] link_frame_word,
  input wire logic enable_pin,
  input wire logic [CHANNELS-1:0] overcurrent_det,
  input wire logic [CHANNELS-1:0] underload_det,
  input wire logic [CHANNELS-1:0] thermal_warning_det,
  input wire logic [CHANNELS-1:0] thermal_shutdown_det,
  input wire logic supply_overvoltage_det,
  input wire logic supply_undervoltage_det,
  output logic [CHANNELS-1:0] high_side_on,
  output logic [CHANNELS-1:0] low_side_on,
  output logic [CHANNELS-1:0] half_bridge_enable_bit,
  output logic [CHANNELS-1:0] half_bridge_config_bit,
  output logic [CHANNELS-1:0] latched_off,
  output logic [CHANNELS-1:0] overcurrent_chan_flag,
  output logic [CHANNELS-1:0] underload_chan_flag,
  output logic [CHANNELS-1:0] thermal_shutdown_chan_flag,
  output logic overcurrent_flag,
  output logic underload_flag,
  output logic thermal_warning_flag,
  output logic thermal_shutdown_flag,
  output logic supply_fail_flag,
  output logic overvoltage_lockout_en,
  output logic underload_shutdown_ctl
);
  // One synchroniser lane per pin and per channel detector, plus the link toggle on top
  localparam int NSYNC = 4 * CHANNELS + 4;

  // Link domain: reset crossing, frame capture and hand-off toggle
  logic link_rst;
  logic [HBFM_FRAME_BITS-1:0] link_word_q;
  logic [HBFM_FRAME_BITS-1:0] link_word_d;
  logic link_toggle_q;
  logic link_toggle_d;

  // Link side leaves reset a few link edges after rst; frames before that are dropped
  hbfm_sync_if #(.WIDTH(1)) rst_link_if ();
  assign rst_link_if.raw = rst;
  assign link_rst = rst_link_if.clean;

  hbfm_sync #(.WIDTH(1)) u_rst_link (
    .clk(link_clk),
    .port(rst_link_if)
  );

  always_comb begin
    link_word_d = link_word_q;
    link_toggle_d = link_toggle_q;
    if (link_rst) begin
      link_word_d = HBFM_RST_WORD;
      link_toggle_d = 1'h0;
    end else if (link_frame_end && (link_frame_count == HBFM_FRAME_LEN)) begin
      link_word_d = link_frame_word;
      link_toggle_d = ~link_toggle_q;
    end
  end

  always_ff @(posedge link_clk) begin
    link_word_q <= link_word_d;
    link_toggle_q <= link_toggle_d;
  end

  // Core domain: enable, supply and detector pins and the frame toggle pass the three-stage synchroniser; rst is used directly
  hbfm_sync_if #(.WIDTH(NSYNC)) pin_if ();
  assign pin_if.raw = {link_toggle_q, enable_pin, supply_overvoltage_det,
                       supply_undervoltage_det, overcurrent_det, underload_det,
                       thermal_warning_det, thermal_shutdown_det};

  hbfm_sync #(.WIDTH(NSYNC)) u_pin_sync (
    .clk(clk),
    .port(pin_if)
  );

  logic toggle_s;
  logic en_pin_s;
  logic ov_s;
  logic uv_s;
  logic [CHANNELS-1:0] oc_s;
  logic [CHANNELS-1:0] uld_s;
  logic [CHANNELS-1:0] tw_s;
  logic [CHANNELS-1:0] tsd_s;

  assign {toggle_s, en_pin_s, ov_s, uv_s, oc_s, uld_s, tw_s, tsd_s} = pin_if.clean;

  // Frame decode; the link word has been stable for many core cycles when the toggle arrives
  logic toggle_seen_q;
  logic toggle_seen_d;
  logic en_pin_q;
  logic en_pin_d;
  logic frame_new;
  logic frame_clear;
  logic pin_clear;
  logic clear_req;

  assign frame_new = toggle_s != toggle_seen_q;
  assign frame_clear = frame_new && link_word_q[HBFM_POS_STATUS_RESET];
  // Either edge of the synced enable pin clears the same latches as a frame reset
  assign pin_clear = en_pin_s != en_pin_q;
  assign clear_req = frame_clear || pin_clear;

  always_comb begin
    toggle_seen_d = toggle_s;
    en_pin_d = en_pin_s;
  end

  // Configuration, latched flags and latched-off state
  logic [CHANNELS-1:0] en_q;
  logic [CHANNELS-1:0] en_d;
  logic [CHANNELS-1:0] cnf_q;
  logic [CHANNELS-1:0] cnf_d;
  logic overvoltage_lockout_en_q;
  logic overvoltage_lockout_en_d;
  logic underload_shutdown_ctl_q;
  logic underload_shutdown_ctl_d;
  logic [CHANNELS-1:0] oc_flag_q;
  logic [CHANNELS-1:0] oc_flag_d;
  logic [CHANNELS-1:0] uld_flag_q;
  logic [CHANNELS-1:0] uld_flag_d;
  logic [CHANNELS-1:0] tsd_flag_q;
  logic [CHANNELS-1:0] tsd_flag_d;
  logic [CHANNELS-1:0] off_q;
  logic [CHANNELS-1:0] off_d;
  logic [CHANNELS-1:0] latch_event;
  logic [CHANNELS-1:0] off_kept;

  always_comb begin
    en_d = en_q;
    cnf_d = cnf_q;
    overvoltage_lockout_en_d = overvoltage_lockout_en_q;
    underload_shutdown_ctl_d = underload_shutdown_ctl_q;
    // Clear takes effect first, so a frame may both reset and reprogram
    off_kept = clear_req ? '0 : off_q;
    if (frame_new) begin
      en_d = link_word_q[HBFM_POS_ENABLE_LSB +: CHANNELS];
      cnf_d = link_word_q[HBFM_POS_CONFIG_LSB +: CHANNELS];
      overvoltage_lockout_en_d = link_word_q[HBFM_POS_OV_LOCKOUT];
      underload_shutdown_ctl_d = link_word_q[HBFM_POS_ULD_SHUTDOWN];
    end
    // A still-present condition re-sets flags over a clear
    oc_flag_d = (clear_req ? '0 : oc_flag_q) | oc_s;
    uld_flag_d = (clear_req ? '0 : uld_flag_q) | uld_s;
    tsd_flag_d = (clear_req ? '0 : tsd_flag_q) | tsd_s;
    latch_event = oc_s | tsd_s | (underload_shutdown_ctl_q ? uld_s : '0);
    off_d = off_kept | latch_event;
    for (int i = 0; i < CHANNELS; i++) begin
      // Channels held off keep zero settings until a clear and a new frame
      if (latch_event[i] || off_kept[i]) begin
        en_d[i] = 1'h0;
        cnf_d[i] = 1'h0;
      end
    end
    if (rst) begin
      en_d = HBFM_RST_CHANNEL;
      cnf_d = HBFM_RST_CHANNEL;
      overvoltage_lockout_en_d = HBFM_RST_OV_LOCKOUT;
      underload_shutdown_ctl_d = HBFM_RST_ULD_SHUTDOWN;
      oc_flag_d = '0;
      uld_flag_d = '0;
      tsd_flag_d = '0;
      off_d = '0;
    end
  end

  always_ff @(posedge clk) begin
    en_q <= en_d;
    cnf_q <= cnf_d;
    overvoltage_lockout_en_q <= overvoltage_lockout_en_d;
    underload_shutdown_ctl_q <= underload_shutdown_ctl_d;
    oc_flag_q <= oc_flag_d;
    uld_flag_q <= uld_flag_d;
    tsd_flag_q <= tsd_flag_d;
    off_q <= off_d;
  end

  // Edge detectors load the synced levels in reset, so no false frame or clear follows it
  always_ff @(posedge clk) begin
    if (rst) begin
      toggle_seen_q <= toggle_s;
      en_pin_q <= en_pin_s;
    end else begin
      toggle_seen_q <= toggle_seen_d;
      en_pin_q <= en_pin_d;
    end
  end

  // Driver outputs and status, all registered
  logic lockout;
  logic [CHANNELS-1:0] drive;
  logic [CHANNELS-1:0] hs_d;
  logic [CHANNELS-1:0] ls_d;
  logic tw_d;
  logic psf_d;
  logic [CHANNELS-1:0] hs_q;
  logic [CHANNELS-1:0] ls_q;
  logic tw_q;
  logic psf_q;

  always_comb begin
    // Lockouts mask drive without touching stored settings
    lockout = uv_s || (ov_s && overvoltage_lockout_en_q);
    // Enable pin low forces all drivers off but leaves the settings in place
    drive = (lockout || !en_pin_s) ? '0 : (en_q & ~off_q);
    hs_d = drive & cnf_q;
    ls_d = drive & ~cnf_q;
    tw_d = |tw_s;
    // Supply flag follows the synced levels and needs no clear
    psf_d = ov_s || uv_s;
    if (rst) begin
      hs_d = '0;
      ls_d = '0;
      tw_d = 1'h0;
      psf_d = 1'h0;
    end
  end

  always_ff @(posedge clk) begin
    hs_q <= hs_d;
    ls_q <= ls_d;
    tw_q <= tw_d;
    psf_q <= psf_d;
  end

  assign high_side_on = hs_q;
  assign low_side_on = ls_q;
  assign half_bridge_enable_bit = en_q;
  assign half_bridge_config_bit = cnf_q;
  assign latched_off = off_q;
  assign overcurrent_chan_flag = oc_flag_q;
  assign underload_chan_flag = uld_flag_q;
  assign thermal_shutdown_chan_flag = tsd_flag_q;
  assign thermal_warning_flag = tw_q;
  assign supply_fail_flag = psf_q;
  assign overvoltage_lockout_en = overvoltage_lockout_en_q;
  assign underload_shutdown_ctl = underload_shutdown_ctl_q;

  // Global summary flags, registered from the channel flags' next values
  logic oc_any_q;
  logic uld_any_q;
  logic tsd_any_q;

  always_ff @(posedge clk) begin
    oc_any_q <= |oc_flag_d;
    uld_any_q <= |uld_flag_d;
    tsd_any_q <= |tsd_flag_d;
  end

  assign overcurrent_flag = oc_any_q;
  assign underload_flag = uld_any_q;
  assign thermal_shutdown_flag = tsd_any_q;
endmodule

// file: tb/hbfm_checker_assertions.sv
// Port checker for the half-bridge fault manager
`timescale 1ns/10ps
module hbfm_checker
  import hbfm_pkg::*;
#(
  parameter int CHANNELS = HBFM_CHANNELS
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic supply_overvoltage_det,
  input wire logic supply_undervoltage_det,
  input wire logic overvoltage_lockout_en,
  input wire logic [CHANNELS-1:0] high_side_on,
  input wire logic [CHANNELS-1:0] low_side_on,
  input wire logic [CHANNELS-1:0] half_bridge_enable_bit,
  input wire logic [CHANNELS-1:0] half_bridge_config_bit,
  input wire logic [CHANNELS-1:0] latched_off,
  input wire logic [CHANNELS-1:0] overcurrent_chan_flag,
  input wire logic [CHANNELS-1:0] thermal_shutdown_chan_flag
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  wire logic [CHANNELS-1:0] drv = high_side_on | low_side_on;
  a_latch_zero: assert property (
    (latched_off & (half_bridge_enable_bit | half_bridge_config_bit)) == '0)
    else $error("latched channel kept settings");
  a_latch_drive: assert property ((drv & $past(latched_off)) == '0)
    else $error("latched channel driven");
  a_oc_latch: assert property ((overcurrent_chan_flag & ~latched_off) == '0)
    else $error("overcurrent without latch");
  a_tsd_latch: assert property ((thermal_shutdown_chan_flag & ~latched_off) == '0)
    else $error("shutdown without latch");
  a_high_cfg: assert property ((high_side_on & ~$past(half_bridge_config_bit)) == '0)
    else $error("high side against config");
  a_drive_en: assert property ((drv & ~$past(half_bridge_enable_bit)) == '0)
    else $error("disabled channel driven");
  a_ov_lock: assert property (
    (supply_overvoltage_det && overvoltage_lockout_en)[*7] |=> drv == '0)
    else $error("overvoltage lockout failed");
  a_uv_hiz: assert property (supply_undervoltage_det[*7] |=> drv == '0)
    else $error("undervoltage left outputs on");
  c_latch: cover property ($rose(latched_off[0]));
  c_clear: cover property ($fell(latched_off[1]));
  c_lock: cover property (supply_undervoltage_det && drv == '0);
endmodule
bind hbfm_top hbfm_checker #(.CHANNELS(CHANNELS)) u_chk (.*);

// file: tb/hbfm_host_model.sv
// Host model handing completed serial frames over on its own link clock
`timescale 1ns/10ps
module hbfm_host_model (
  output logic link_clk = 1'b0,
  output logic link_frame_end = 1'b0,
  output logic [4:0] link_frame_count = 5'h00,
  output logic [15:0] link_frame_word = 16'h0000
);
  // Link clock runs only while tick is called, for n periods of 125 ns, whether or not a frame is in flight
  task automatic tick(input int n);
    repeat (n) begin
      #62.5 link_clk = 1'b1;
      #62.5 link_clk = 1'b0;
    end
  endtask
  // Released lines show the inverse, never the stale frame
  task automatic send(input logic [15:0] w, input logic [4:0] n);
    tick(2);
    link_frame_word = w;
    link_frame_count = n;
    link_frame_end = 1'b1;
    tick(1);
    link_frame_end = 1'b0;
    link_frame_word = ~w;
    link_frame_count = ~n;
    tick(3);
  endtask
endmodule

// file: tb/tb.sv
// Self-checking bench for the half-bridge fault manager
`timescale 1ns/10ps
module tb;
  localparam logic [5:0] Z = 6'h00;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic enable_pin = 1'b1;
  logic [5:0] overcurrent_det = Z, underload_det = Z, thermal_warning_det = Z;
  logic [5:0] thermal_shutdown_det = Z;
  logic supply_overvoltage_det = 1'b0, supply_undervoltage_det = 1'b0;
  logic link_clk, link_frame_end;
  logic [4:0] link_frame_count;
  logic [15:0] link_frame_word;
  logic [5:0] high_side_on, low_side_on, half_bridge_enable_bit, half_bridge_config_bit;
  logic [5:0] latched_off, overcurrent_chan_flag, underload_chan_flag;
  logic [5:0] thermal_shutdown_chan_flag;
  logic overcurrent_flag, underload_flag, thermal_warning_flag, thermal_shutdown_flag;
  logic supply_fail_flag, overvoltage_lockout_en, underload_shutdown_ctl;
  int error_cnt = 0;
  int checks = 0;
  hbfm_top DUT (.*);
  hbfm_host_model host (.*);
  always #4 clk = ~clk;
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic drv(input logic [11:0] exp);
    chk({4'h0, high_side_on, low_side_on}, {4'h0, exp});
  endtask
  task automatic put(input logic [5:0] oc, ul, tw, ts, input logic [1:0] sup);
    @(posedge clk);
    overcurrent_det <= oc;
    underload_det <= ul;
    thermal_warning_det <= tw;
    thermal_shutdown_det <= ts;
    {supply_undervoltage_det, supply_overvoltage_det} <= sup;
    repeat (8) @(posedge clk);
    #1;
  endtask
  task automatic summarize();
    $display("errors=%0d checks=%0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #200000;
    error_cnt++;
    summarize();
  end
  initial begin
    fork
      repeat (8) @(posedge clk);
      host.tick(5);
    join
    chk(latched_off, Z);
    @(posedge clk);
    rst <= 1'b0;
    host.tick(4);
    put(Z, Z, Z, Z, 2'h0);
    host.send(16'h1fd5, 5'h10);
    drv(12'ha95);
    put(6'h01, Z, Z, Z, 2'h0);
    chk(half_bridge_enable_bit, 6'h3e);
    drv(12'ha94);
    put(Z, Z, Z, Z, 2'h0);
    chk(overcurrent_flag, 1'b1);
    host.send(16'h9fd5, 5'h0f);
    chk(latched_off, 6'h01);
    put(6'h01, Z, Z, Z, 2'h0);
    host.send(16'h9fd5, 5'h10);
    chk(overcurrent_chan_flag, 6'h01);
    put(Z, Z, Z, Z, 2'h0);
    host.send(16'h9fd5, 5'h10);
    drv(12'ha95);
    put(Z, 6'h02, Z, Z, 2'h0);
    drv(12'ha95);
    put(Z, Z, Z, Z, 2'h0);
    chk(underload_chan_flag, 6'h02);
    host.send(16'hbfd5, 5'h10);
    chk(underload_shutdown_ctl, 1'b1);
    chk(underload_flag, 1'b0);
    put(Z, 6'h02, Z, Z, 2'h0);
    chk(latched_off, 6'h02);
    put(Z, Z, Z, Z, 2'h0);
    @(posedge clk);
    enable_pin <= 1'b0;
    put(Z, Z, Z, Z, 2'h0);
    @(posedge clk);
    enable_pin <= 1'b1;
    put(Z, Z, Z, Z, 2'h0);
    drv(12'ha15);
    chk(half_bridge_config_bit, 6'h28);
    host.send(16'h1fd5, 5'h10);
    put(Z, Z, 6'h04, 6'h08, 2'h0);
    chk(thermal_warning_flag, 1'b1);
    drv(12'h895);
    chk(thermal_shutdown_chan_flag, 6'h08);
    host.send(16'h9fd5, 5'h10);
    chk(thermal_shutdown_flag, 1'b1);
    put(Z, Z, Z, Z, 2'h0);
    chk(thermal_warning_flag, 1'b0);
    host.send(16'h9fd5, 5'h10);
    drv(12'ha95);
    put(Z, Z, Z, Z, 2'h1);
    chk(supply_fail_flag, 1'b1);
    drv(12'h000);
    put(Z, Z, Z, Z, 2'h0);
    drv(12'ha95);
    host.send(16'h1fd4, 5'h10);
    chk(overvoltage_lockout_en, 1'b0);
    put(Z, Z, Z, Z, 2'h1);
    drv(12'ha95);
    put(Z, Z, Z, Z, 2'h2);
    drv(12'h000);
    put(Z, Z, Z, Z, 2'h0);
    drv(12'ha95);
    chk(supply_fail_flag, 1'b0);
    summarize();
  end
endmodule
